/* fhr_defs.vh */
/*
 * Prefilter constants: map, fields, resets, coefficients, widths.
 * Assumes inclusion by bare name.
 */
// What this block does
// [RQ1] Six-tap fixed FIR, 5-bit coefficients, no decimation.
// [RQ2] Coefficients -2, 3, 15, 15, 3, -2.
// [RQ3] Its enable bit at 0 bypasses it.
// [RQ4] Its rate follows upstream half-band: full if bypassed, half if active.
// [RQ5] Software keeps its rates at most 75 MHz.
// [RQ6] Half-band: 27-tap symmetric, decimate-by-2, 20-bit data, 12-bit coefficients.
// [RQ7] Half-band odd taps 2,-11,32,-78,169,-373,1282 mirrored, centre 2048, rest zero.
// [RQ8] Half-band enable bit at 0 bypasses it.
// [RQ9] Software keeps half-band input at most 75 MHz, output 37.5 MHz.
// [RQ10] Router lets any back end take I and Q of any front end.
// [RQ11] 3-bit select: 000-011 channels 0-3, 1x0 channel 4, 1x1 channel 5.
// [RQ12] Single-rate FIR: no decimation, up to eight taps, 6-bit coefficients, 20-bit data.
// [RQ13] Tap count is a 3-bit field holding taps minus one.
// [RQ14] Each channel has eight writable coefficient registers.
// [RQ15] Symmetry bit mirrors the first coefficient half; eight taps maximum.
// [RQ16] One tap per clock, or per two clocks at half rate.
// [RQ17] Half rate only when rate times taps fits half the clock.
// [RQ18] Its input and output rates are equal.
// [RQ19] Bypass bit passes samples unchanged.
// [RQ20] Upstream half-band decimation sets the incoming strobe rate.
// [RQ21] Stages strobe samples; decimator strobes every second input.
// [RQ22] All delay lines clear to zero at reset.
`ifndef FHR_DEFS_VH
`define FHR_DEFS_VH

// ----------------------------------------------------------------------
// Data and map geometry
// ----------------------------------------------------------------------
`define FHR_DW            20
`define FHR_AW            9
`define FHR_CH_SHIFT      6
`define FHR_NTAP          8

// ----------------------------------------------------------------------
// Register offsets within one channel block (stride 0x40)
// ----------------------------------------------------------------------
`define FHR_OFS_CASCADE   6'h00
`define FHR_OFS_SRCTRL    6'h04
`define FHR_OFS_STATUS    6'h08
`define FHR_OFS_COEF0     6'h20
`define FHR_OFS_COEF7     6'h3c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FHR_CAS_FIR_EN    0
`define FHR_CAS_HB_EN     1
`define FHR_SR_SEL_LO     0
`define FHR_SR_SEL_HI     2
`define FHR_SR_TAP_LO     3
`define FHR_SR_TAP_HI     5
`define FHR_SR_SYM        6
`define FHR_SR_HALF       7
`define FHR_SR_BYPASS     8
`define FHR_ST_BUSY       0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FHR_CAS_RST       2'h0
`define FHR_SR_RST        9'h100
`define FHR_COEF_RST      6'h00

// ----------------------------------------------------------------------
// Fixed coefficients and output shifts
// ----------------------------------------------------------------------
`define FHR_FIR_C05       5'sh1e
`define FHR_FIR_C14       5'sh03
`define FHR_FIR_C23       5'sh0f
`define FHR_FIR_SHIFT     4
`define FHR_HB_C0         13'sh0002
`define FHR_HB_C2         13'sh1ff5
`define FHR_HB_C4         13'sh0020
`define FHR_HB_C6         13'sh1fb2
`define FHR_HB_C8         13'sh00a9
`define FHR_HB_C10        13'sh1e8b
`define FHR_HB_C12        13'sh0502
`define FHR_HB_CMID       13'sh0800
`define FHR_HB_SHIFT      12
`define FHR_SR_SHIFT      5

`endif

/* fhr_fixed_cascade.v */
/*
 * One I or Q lane: six-tap prefilter, then 27-tap decimating half-band.
 * Assumes a strobed stream on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fhr_defs.vh"

module fhr_fixed_cascade #(
    parameter DW = `FHR_DW
) (
    // Clock and reset
    input  wire                 i_clk,
    input  wire                 i_reset_n,
    // Configuration
    input  wire                 i_fir_en,
    input  wire                 i_hb_en,
    // Input stream
    input  wire                 i_stb,
    input  wire signed [DW-1:0] i_data,
    // Output stream
    output wire                 o_stb,
    output wire signed [DW-1:0] o_data
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Clamp a wide accumulator to the sample width
    function [DW-1:0] sat;
        input signed [39:0] v;
        begin
            if (v > $signed({{(41-DW){1'b0}}, {(DW-1){1'b1}}}))
                sat = {1'b0, {(DW-1){1'b1}}};
            else if (v < -$signed({{(41-DW){1'b0}}, 1'b1, {(DW-1){1'b0}}}))
                sat = {1'b1, {(DW-1){1'b0}}};
            else
                sat = v[DW-1:0];
        end
    endfunction

    // Half-band coefficient by delay index; even taps and centre tap 13 nonzero, mirrored
    function signed [12:0] hb_coef;
        input integer k;
        begin
            case ((k > 13) ? 26 - k : k)
                0:       hb_coef = `FHR_HB_C0;
                2:       hb_coef = `FHR_HB_C2;
                4:       hb_coef = `FHR_HB_C4;
                6:       hb_coef = `FHR_HB_C6;
                8:       hb_coef = `FHR_HB_C8;
                10:      hb_coef = `FHR_HB_C10;
                12:      hb_coef = `FHR_HB_C12;
                13:      hb_coef = `FHR_HB_CMID;
                default: hb_coef = 13'sh0000;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Six-tap prefilter
    // ------------------------------------------------------------------
    reg signed [DW-1:0] fir_dl_q [0:4];
    reg signed [DW-1:0] fir_q;
    reg                 fir_stb_q;
    reg signed [39:0]   fir_acc;
    integer             i;

    // Products of new sample and five stored ones
    always @* begin
        fir_acc = `FHR_FIR_C05 * i_data + `FHR_FIR_C14 * fir_dl_q[0]     // RQ1 RQ2
                + `FHR_FIR_C23 * fir_dl_q[1] + `FHR_FIR_C23 * fir_dl_q[2]
                + `FHR_FIR_C14 * fir_dl_q[3] + `FHR_FIR_C05 * fir_dl_q[4];
    end

    // Delay line; one output per input
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (i = 0; i < 5; i = i + 1)
                fir_dl_q[i] <= {DW{1'b0}};                                // RQ22
            fir_q     <= {DW{1'b0}};
            fir_stb_q <= 1'b0;
        end else begin
            fir_stb_q <= i_stb;                                           // RQ21 RQ4
            if (i_stb) begin
                fir_dl_q[0] <= i_data;
                for (i = 1; i < 5; i = i + 1)
                    fir_dl_q[i] <= fir_dl_q[i-1];
                fir_q <= i_fir_en ? sat(fir_acc >>> `FHR_FIR_SHIFT) : i_data; // RQ3
            end
        end
    end

    // ------------------------------------------------------------------
    // 27-tap decimate-by-2 half-band
    // ------------------------------------------------------------------
    reg signed [DW-1:0] hb_dl_q [0:25];
    reg signed [DW-1:0] hb_q;
    reg                 hb_stb_q;
    reg                 hb_phase_q;
    reg signed [39:0]   hb_acc;
    reg signed [DW-1:0] hb_tap;
    integer             k;

    // Convolution over new sample and 26 stored ones
    always @* begin
        hb_acc = 40'sh0;
        hb_tap = {DW{1'b0}};
        for (k = 0; k < 27; k = k + 1) begin
            hb_tap = (k == 0) ? fir_q : hb_dl_q[(k == 0) ? 0 : k - 1];
            hb_acc = hb_acc + hb_coef(k) * hb_tap;                        // RQ6 RQ7
        end
    end

    // Every second input when active, every input when bypassed
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (k = 0; k < 26; k = k + 1)
                hb_dl_q[k] <= {DW{1'b0}};                                 // RQ22
            hb_q       <= {DW{1'b0}};
            hb_stb_q   <= 1'b0;
            hb_phase_q <= 1'b0;
        end else begin
            hb_stb_q <= 1'b0;
            if (fir_stb_q) begin
                hb_dl_q[0] <= fir_q;
                for (k = 1; k < 26; k = k + 1)
                    hb_dl_q[k] <= hb_dl_q[k-1];
                if (!i_hb_en) begin
                    hb_q       <= fir_q;                                  // RQ8
                    hb_stb_q   <= 1'b1;
                    hb_phase_q <= 1'b0;
                end else begin
                    hb_phase_q <= ~hb_phase_q;
                    if (hb_phase_q) begin
                        hb_q     <= sat(hb_acc >>> `FHR_HB_SHIFT);        // RQ6
                        hb_stb_q <= 1'b1;                                 // RQ21
                    end
                end
            end
        end
    end

    assign o_stb  = hb_stb_q;
    assign o_data = hb_q;

endmodule
`default_nettype wire

/* fhr_prefilter.v */
/*
 * Receive prefilter: fixed cascades,
 * router and single-rate FIR per channel,
 * with APB control and coefficient registers.
 * Assumes strobed I/Q streams on i_clk, the fast
 * processing clock, and a consumer that never stalls.
 */
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "fhr_defs.vh"

module fhr_prefilter #(
    parameter NCH = 6,
    parameter DW  = `FHR_DW
) (
    // Clock and reset
    input  wire                  i_clk,
    input  wire                  i_reset_n,
    // APB slave
    input  wire                  i_psel,
    input  wire                  i_penable,
    input  wire                  i_pwrite,
    input  wire [`FHR_AW-1:0]    i_paddr,
    input  wire [31:0]           i_pwdata,
    output wire [31:0]           o_prdata,
    output wire                  o_pready,
    output wire                  o_pslverr,
    // Front-end streams from the first cascade
    input  wire [NCH-1:0]        i_fe_stb,
    input  wire [NCH*DW-1:0]     i_fe_i,
    input  wire [NCH*DW-1:0]     i_fe_q,
    // Back-end streams to the decimating filters
    output wire [NCH-1:0]        o_be_stb,
    output wire [NCH*DW-1:0]     o_be_i,
    output wire [NCH*DW-1:0]     o_be_q
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Clamp a wide accumulator to the sample width
    function [DW-1:0] sat;
        input signed [39:0] v;
        begin
            if (v > $signed({{(41-DW){1'b0}}, {(DW-1){1'b1}}}))
                sat = {1'b0, {(DW-1){1'b1}}};
            else if (v < -$signed({{(41-DW){1'b0}}, 1'b1, {(DW-1){1'b0}}}))
                sat = {1'b1, {(DW-1){1'b0}}};
            else
                sat = v[DW-1:0];
        end
    endfunction

    // Source select to front-end index; bit 1 ignored when bit 2 set
    function [2:0] src_of;
        input [2:0] sel;
        begin
            if (sel[2])
                src_of = sel[0] ? 3'h5 : 3'h4;                            // RQ11
            else
                src_of = {1'b0, sel[1:0]};
        end
    endfunction

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    reg [1:0]   cas_ctrl_q [0:NCH-1];
    reg [8:0]   sr_ctrl_q  [0:NCH-1];
    reg [5:0]   coef_q     [0:NCH*`FHR_NTAP-1];
    reg [31:0]  prdata_q;
    reg         pready_q;
    reg         pslverr_q;
    wire [NCH-1:0] be_busy;

    // ------------------------------------------------------------------
    // APB address decode
    // ------------------------------------------------------------------
    wire [2:0] a_ch  = i_paddr[`FHR_AW-1:`FHR_CH_SHIFT];
    wire [5:0] a_ofs = i_paddr[`FHR_CH_SHIFT-1:0];
    wire [2:0] a_tap = a_ofs[4:2];
    reg        a_hit;
    reg        a_ro;
    reg [31:0] a_rd;

    // Decode address, build read word
    always @* begin
        a_hit = 1'b0;
        a_ro  = 1'b0;
        a_rd  = 32'h0;
        if ({29'h0, a_ch} >= NCH || a_ofs[1:0] != 2'h0) begin
            a_hit = 1'b0;
        end else if (a_ofs == `FHR_OFS_CASCADE) begin
            a_hit = 1'b1;
            a_rd  = {30'h0, cas_ctrl_q[a_ch]};
        end else if (a_ofs == `FHR_OFS_SRCTRL) begin
            a_hit = 1'b1;
            a_rd  = {23'h0, sr_ctrl_q[a_ch]};
        end else if (a_ofs == `FHR_OFS_STATUS) begin
            a_hit = 1'b1;
            a_ro  = 1'b1;
            a_rd  = {31'h0, be_busy[a_ch]};
        end else if (a_ofs >= `FHR_OFS_COEF0 && a_ofs <= `FHR_OFS_COEF7) begin
            a_hit = 1'b1;
            a_rd  = {26'h0, coef_q[{a_ch, a_tap}]};                       // RQ14
        end
    end

    // ------------------------------------------------------------------
    // APB: answer in the cycle after setup
    // ------------------------------------------------------------------
    wire ap_setup  = i_psel & ~i_penable & ~pready_q;
    wire ap_commit = i_psel & i_penable & pready_q;

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= ap_setup;
            if (ap_setup) begin
                prdata_q  <= i_pwrite ? 32'h0 : a_rd;
                pslverr_q <= ~a_hit | (a_ro & i_pwrite);
            end else if (ap_commit) begin
                prdata_q  <= 32'h0;
                pslverr_q <= 1'b0;
            end
        end
    end

    // Writes land on the completing access edge
    integer r;
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (r = 0; r < NCH; r = r + 1) begin
                cas_ctrl_q[r] <= `FHR_CAS_RST;
                sr_ctrl_q[r]  <= `FHR_SR_RST;
            end
            for (r = 0; r < NCH*`FHR_NTAP; r = r + 1)
                coef_q[r] <= `FHR_COEF_RST;
        end else if (ap_commit && i_pwrite && !pslverr_q) begin
            if (a_ofs == `FHR_OFS_CASCADE)
                cas_ctrl_q[a_ch] <= i_pwdata[1:0];                        // RQ3 RQ8
            else if (a_ofs == `FHR_OFS_SRCTRL)
                sr_ctrl_q[a_ch] <= i_pwdata[8:0];
            else if (a_ofs >= `FHR_OFS_COEF0)
                coef_q[{a_ch, a_tap}] <= i_pwdata[5:0];                   // RQ14
        end
    end

    assign o_prdata  = prdata_q;
    assign o_pready  = pready_q;
    assign o_pslverr = pslverr_q;

    // ------------------------------------------------------------------
    // Front ends: second fixed cascade per channel
    // ------------------------------------------------------------------
    wire [NCH-1:0]    fe_stb;
    wire [NCH*DW-1:0] fe_i;
    wire [NCH*DW-1:0] fe_q;

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_fe
            // Strobe rate carries upstream decimation
            fhr_fixed_cascade #(.DW(DW)) u_cas_i (                        // RQ20
                .i_clk     (i_clk),
                .i_reset_n (i_reset_n),
                .i_fir_en  (cas_ctrl_q[g][`FHR_CAS_FIR_EN]),
                .i_hb_en   (cas_ctrl_q[g][`FHR_CAS_HB_EN]),
                .i_stb     (i_fe_stb[g]),
                .i_data    (i_fe_i[g*DW +: DW]),
                .o_stb     (fe_stb[g]),
                .o_data    (fe_i[g*DW +: DW])
            );
            // Q lane runs in lockstep with I
            fhr_fixed_cascade #(.DW(DW)) u_cas_q (
                .i_clk     (i_clk),
                .i_reset_n (i_reset_n),
                .i_fir_en  (cas_ctrl_q[g][`FHR_CAS_FIR_EN]),
                .i_hb_en   (cas_ctrl_q[g][`FHR_CAS_HB_EN]),
                .i_stb     (i_fe_stb[g]),
                .i_data    (i_fe_q[g*DW +: DW]),
                .o_stb     (),
                .o_data    (fe_q[g*DW +: DW])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Back ends: router and single-rate programmable filter
    // ------------------------------------------------------------------
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_be
            wire [8:0]          ctl    = sr_ctrl_q[g];
            wire [2:0]          src    = src_of(ctl[`FHR_SR_SEL_HI:`FHR_SR_SEL_LO]);
            wire [2:0]          last   = ctl[`FHR_SR_TAP_HI:`FHR_SR_TAP_LO];
            wire                sym    = ctl[`FHR_SR_SYM];
            wire                half   = ctl[`FHR_SR_HALF];
            wire                bypass = ctl[`FHR_SR_BYPASS];
            // Router: any front end into this back end
            wire                rt_stb = fe_stb[src];                     // RQ10
            wire signed [DW-1:0] rt_i  = fe_i[src*DW +: DW];
            wire signed [DW-1:0] rt_q  = fe_q[src*DW +: DW];

            reg [`FHR_NTAP*DW-1:0] dli_q;
            reg [`FHR_NTAP*DW-1:0] dlq_q;
            reg                    busy_q;
            reg                    tick_q;
            reg [2:0]              tap_q;
            reg signed [39:0]      acc_i_q;
            reg signed [39:0]      acc_q_q;
            reg signed [DW-1:0]    out_i_q;
            reg signed [DW-1:0]    out_q_q;
            reg                    out_stb_q;

            // Coefficient index, mirrored in the upper half when symmetric
            wire [2:0]  cidx  = (sym && tap_q > {1'b0, last[2:1]}) ? last - tap_q : tap_q; // RQ15
            wire signed [5:0]    cf   = coef_q[g*`FHR_NTAP + cidx];
            wire signed [DW-1:0] di   = dli_q[tap_q*DW +: DW];
            wire signed [DW-1:0] dq   = dlq_q[tap_q*DW +: DW];
            // One tap per clock, or per two clocks at half rate
            wire        step  = busy_q & (~half | tick_q);                // RQ16
            wire signed [39:0] nxt_i = acc_i_q + cf * di;
            wire signed [39:0] nxt_q = acc_q_q + cf * dq;

            // Delay lines, tap sequencer and output register
            always @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    dli_q     <= {(`FHR_NTAP*DW){1'b0}};                  // RQ22
                    dlq_q     <= {(`FHR_NTAP*DW){1'b0}};
                    busy_q    <= 1'b0;
                    tick_q    <= 1'b0;
                    tap_q     <= 3'h0;
                    acc_i_q   <= 40'sh0;
                    acc_q_q   <= 40'sh0;
                    out_i_q   <= {DW{1'b0}};
                    out_q_q   <= {DW{1'b0}};
                    out_stb_q <= 1'b0;
                end else begin
                    out_stb_q <= 1'b0;
                    tick_q    <= ~tick_q;
                    if (rt_stb) begin
                        dli_q <= {dli_q[(`FHR_NTAP-1)*DW-1:0], rt_i};
                        dlq_q <= {dlq_q[(`FHR_NTAP-1)*DW-1:0], rt_q};
                    end
                    if (bypass) begin
                        busy_q    <= 1'b0;
                        out_stb_q <= rt_stb;                              // RQ19 RQ21
                        if (rt_stb) begin
                            out_i_q <= rt_i;
                            out_q_q <= rt_q;
                        end
                    end else if (rt_stb) begin
                        // New sample restarts the sum
                        busy_q  <= 1'b1;
                        tick_q  <= 1'b0;
                        tap_q   <= 3'h0;
                        acc_i_q <= 40'sh0;
                        acc_q_q <= 40'sh0;
                    end else if (step) begin
                        acc_i_q <= nxt_i;                                 // RQ12
                        acc_q_q <= nxt_q;
                        tap_q   <= tap_q + 3'h1;
                        if (tap_q == last) begin                          // RQ13
                            busy_q    <= 1'b0;
                            out_i_q   <= sat(nxt_i >>> `FHR_SR_SHIFT);
                            out_q_q   <= sat(nxt_q >>> `FHR_SR_SHIFT);
                            out_stb_q <= 1'b1;                            // RQ18
                        end
                    end
                end
            end

            assign be_busy[g]          = busy_q;
            assign o_be_stb[g]         = out_stb_q;
            assign o_be_i[g*DW +: DW]  = out_i_q;
            assign o_be_q[g*DW +: DW]  = out_q_q;
        end
    endgenerate

endmodule
`default_nettype wire

/* fhr_prefilter_monitor.sv */
/* Checker on fhr_prefilter ports: bus answers, refusals, strobes after reset.
   Assumes binding to the design top, one clock. */
`timescale 1ns/100ps
`default_nettype none
module fhr_prefilter_monitor #(parameter NCH = 6) (
    input wire logic           i_clk, i_reset_n, i_psel, i_penable, i_pwrite,
    input wire logic [8:0]     i_paddr,
    input wire logic [31:0]    o_prdata,
    input wire logic           o_pready, o_pslverr,
    input wire logic [NCH-1:0] i_fe_stb, o_be_stb
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Setup phase of a bus transfer
    wire setup = i_psel && !i_penable;
    property p_rdy; setup |=> o_pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no answer after setup");
    property p_pulse; o_pready |=> !o_pready; endproperty
    a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
    property p_idle; !o_pready |-> o_prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    property p_err; o_pslverr |-> o_pready; endproperty
    a_err: assert property (p_err) else $error("error without answer");
    property p_ro; setup && i_pwrite && i_paddr[5:0] == 6'h08 |=> o_pslverr; endproperty
    a_ro: assert property (p_ro) else $error("status write accepted");
    property p_far; setup && i_paddr[8:6] >= NCH |=> o_pslverr && o_prdata == 32'h0; endproperty
    a_far: assert property (p_far) else $error("absent channel accepted");
    property p_ctl; setup && i_paddr[8:6] < NCH && i_paddr[5:0] == 6'h04 |=> !o_pslverr; endproperty
    a_ctl: assert property (p_ctl) else $error("control access refused");
    property p_wake; $rose(i_reset_n) |-> o_be_stb == '0 ##1 o_be_stb == '0; endproperty
    a_wake: assert property (p_wake) else $error("stale strobe after reset");
endmodule
bind fhr_prefilter fhr_prefilter_monitor #(.NCH(NCH)) u_mon (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_fe_stb(i_fe_stb), .o_be_stb(o_be_stb));
`default_nettype wire

/* fhr_src.sv */
/* Upstream model: one strobed I/Q sample per send on a chosen channel.
   Assumes callers on the same clock. */
`timescale 1ns/100ps
`default_nettype none
module fhr_src #(parameter NCH = 6, parameter DW = 20) (
    input  wire logic              i_clk,
    output var  logic [NCH-1:0]    o_stb,
    output var  logic [NCH*DW-1:0] o_i, o_q
);
    initial begin
        o_stb = '0;
        o_i = '0;
        o_q = '0;
    end
    // One sample, then data lines show inverted junk
    task automatic send(input int ch, input logic [DW-1:0] vi, input logic [DW-1:0] vq);
        @(posedge i_clk);
        o_stb[ch] <= 1'b1;
        o_i[ch*DW+:DW] <= vi;
        o_q[ch*DW+:DW] <= vq;
        @(posedge i_clk);
        o_stb <= '0;
        o_i <= ~o_i;
        o_q <= ~o_q;
        repeat (18) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

/* fhr_prefilter_bench.sv */
/* Bench for fhr_prefilter: registers, filter rows, router, half-band, reset.
   Assumes fhr_src feeds front ends; back end 0 observed. */
`timescale 1ns/100ps
`default_nettype none
module fhr_prefilter_bench;
    typedef struct {logic [1:0] casc; logic [8:0] sr; logic [19:0] amp; logic [119:0] exp;} fhr_row_t;
    logic clk, rst_n, psel, penable, pwrite, err;
    logic [8:0] paddr;
    logic [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [5:0] fe_stb, be_stb;
    wire [119:0] fe_i, fe_q, be_i, be_q;
    int err_count, checked, cyc, t_in, lat_q[$];
    logic [39:0] out_q[$];
    fhr_row_t rows[5];
    fhr_prefilter u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_fe_stb(fe_stb), .i_fe_i(fe_i), .i_fe_q(fe_q), .o_be_stb(be_stb), .o_be_i(be_i), .o_be_q(be_q));
    fhr_src u_src (.i_clk(clk), .o_stb(fe_stb), .o_i(fe_i), .o_q(fe_q));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // Log back end 0 samples and delay from last input strobe
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (|fe_stb) t_in <= cyc;
        if (be_stb[0] === 1'b1) begin
            out_q.push_back({be_q[19:0], be_i[19:0]});
            lat_q.push_back(cyc - t_in);
        end
    end
    task chk(input string n, input logic [39:0] s, input logic [39:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Configure, send n samples of a, then seven zeros
    task run(input logic [1:0] c, input logic [8:0] s, input int ch, input logic [19:0] a, input int n);
        apb(1, 9'h000, {30'h0, c}, rd, err);
        apb(1, 9'h004, {23'h0, s}, rd, err);
        out_q.delete();
        lat_q.delete();
        for (int k = 0; k < n + 7; k++) u_src.send(ch, (k < n) ? a : 20'h0, (k < n) ? -a : 20'h0);
    endtask
    task report_and_stop;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
        rows = '{'{2'h0, 9'h100, 20'h5, {20'h5, 100'h0}},
                 '{2'h1, 9'h100, 20'h10, {20'hffffe, 20'h3, 20'hf, 20'hf, 20'h3, 20'hffffe}},
                 '{2'h0, 9'h010, 20'h20, {20'h1f, 20'hfffe0, 20'h10, 60'h0}},
                 '{2'h0, 9'h060, 20'h20, {20'h1f, 20'hfffe0, 20'h10, 20'hfffe0, 20'h1f, 20'h0}},
                 '{2'h0, 9'h0e0, 20'h20, {20'h1f, 20'hfffe0, 20'h10, 20'hfffe0, 20'h1f, 20'h0}}};
        repeat (5) @(posedge clk);
        rst_n <= 1;
        apb(0, 9'h004, 0, rd, err); chk("srctrl reset", rd, 32'h100);
        apb(0, 9'h180, 0, rd, err); chk("unmapped", {err, rd}, 33'h100000000);
        apb(1, 9'h008, 1, rd, err); chk("status write", err, 1);
        apb(1, 9'h020, 32'h1f, rd, err);
        apb(1, 9'h024, 32'h20, rd, err);
        apb(1, 9'h028, 32'h10, rd, err);
        apb(0, 9'h024, 0, rd, err); chk("coef1", {err, rd}, 32'h20);
        $display("test registers done");
        foreach (rows[r]) begin
            run(rows[r].casc, rows[r].sr, 0, rows[r].amp, 1);
            chk("count", out_q.size(), 8);
            for (int k = 0; k < 6; k++) chk("sample", out_q[k][19:0], rows[r].exp[(5-k)*20+:20]);
            $display("test row %0d done", r);
        end
        for (int c = 0; c < 8; c++) begin
            run(0, 9'h100 | c[8:0], (c < 4) ? c : 4 + c % 2, 20'h100 + c[19:0], 1);
            chk("route", out_q[0], {-(20'h100 + c[19:0]), 20'h100 + c[19:0]});
            chk("latency", lat_q[0], 3);
        end
        $display("test router done");
        run(2, 9'h100, 0, 20'h01000, 28);
        chk("decimated count", out_q.size(), 17);
        chk("dc gain", out_q[13][19:0], 20'h00ffe);
        $display("test half-band done");
        run(1, 9'h100, 0, 20'h01000, 0);
        repeat (6) u_src.send(0, 20'h01000, 20'h0);
        rst_n <= 0;
        repeat (5) @(posedge clk);
        rst_n <= 1;
        apb(0, 9'h000, 0, rd, err); chk("cascade reset", rd, 0);
        run(1, 9'h100, 0, 20'h10, 1);
        chk("fresh line", out_q[0][19:0], 20'hffffe);
        $display("test reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
